// ===== src/crpc_params.svh
// Named offsets, field positions, reset values and timing counts of the clock/reset/power block.
`ifndef CRPC_PARAMS_SVH
`define CRPC_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CRPC_ADDR_W 8
`define CRPC_OFS_SYSCTRL 8'h00
`define CRPC_OFS_STATUS 8'h04
`define CRPC_OFS_MASK 8'h08
`define CRPC_OFS_MODRST 8'h0c
`define CRPC_OFS_MODE 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define CRPC_BIT_STOP_SEL 0
`define CRPC_BIT_LDO_LP 1
`define CRPC_BIT_SLOW_SUB 12
`define CRPC_BIT_FAST_SUB 13
`define CRPC_BIT_CLK_TOP 14
`define CRPC_EV_PAD_WAKE 0
`define CRPC_EV_LP_ENTRY 1
`define CRPC_EV_WAKE 2
`define CRPC_EV_PIN_RST 3
`define CRPC_EV_WATCHDOG_RST 4
`define CRPC_EV_W 5
`define CRPC_NUM_MODULES 8

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define CRPC_SYSCTRL_RST 32'h0000_0000
`define CRPC_SYSCTRL_MASK 32'h0000_7003
`define CRPC_STATUS_RST 5'h00
`define CRPC_MASK_RST 5'h00
`define CRPC_RESP_OKAY 2'h0
`define CRPC_RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CRPC_CLK_PERIOD_NS 10
`define CRPC_RST_HOLD_NS 160
`define CRPC_RST_HOLD_CYC ((`CRPC_RST_HOLD_NS + `CRPC_CLK_PERIOD_NS - 1) / `CRPC_CLK_PERIOD_NS)
`define CRPC_CNT_W 5

`endif

// ===== src/crpc_pkg.sv
// Types shared by the clock/reset/power block.
package crpc_pkg;

  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_DEEP = 2'h3,
    MODE_STOP = 2'h2
  } crpc_mode_type;

  typedef enum logic [1:0] {
    SRC_INT_FAST = 2'h0,
    SRC_EXT_FAST = 2'h1,
    SRC_INT_SLOW = 2'h2,
    SRC_EXT_SLOW = 2'h3
  } crpc_src_type;

  typedef enum logic [1:0] {
    REG_ACTIVE = 2'h0,
    REG_STANDBY = 2'h1,
    REG_LOW_POWER = 2'h2
  } crpc_reg_type;

  typedef struct packed {
    logic fastIntEn;
    logic fastExtEn;
    logic slowIntEn;
    logic slowExtEn;
    logic sysClkEn;
    logic cpuClkEn;
  } crpc_clk_ctl_type;

  typedef struct packed {
    logic debugN;
    logic chipN;
    logic flashN;
    logic padN;
  } crpc_scope_type;

endpackage : crpc_pkg

// ===== src/crpc_sync.sv
// Two-flop synchroniser for levels arriving from pins.
`timescale 1ns/100ps
module crpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] resetValue,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  // The reset value is a tie-off constant at every instance.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= '0;
      q <= '0;
    end else if (clkEn) begin
      stage1 <= d ^ resetValue;
      q <= stage1;
    end
  end

endmodule : crpc_sync

// ===== src/crpc_top.sv
// Clock selection, reset scope distribution and low-power mode sequencing.
//
// Overview of operation
// - Clock source from control field three bits
// - Top zero: fast sub-select picks fast source
// - Top one: slow sub-select picks slow source
// - Pin reset resets all but debug
// - Watchdog reset spares flash and pad logic
// - Module reset touches only its module
// - Sleep: regulator as in run, wake controller runs
// - DeepSleep: regulator standby, fast clocks stopped
// - Stop: all clocks off, regulator standby
// - Only pad wake (interrupting) or a pin/watchdog reset leaves Stop
// - Low-speed run: slow clock, low-power regulator
// - Low-speed run ends only by reset
`timescale 1ns/100ps
`include "crpc_params.svh"
module crpc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`CRPC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CRPC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic coreSleepReq,
  input wire logic coreDeepSleep,
  input wire logic coreWakeEvent,
  input wire logic watchdogReset,
  input wire logic padWake,
  input wire logic resetPin_n,
  output crpc_pkg::crpc_clk_ctl_type clkCtl,
  output crpc_pkg::crpc_src_type sysClkSource,
  output crpc_pkg::crpc_reg_type regulatorMode,
  output crpc_pkg::crpc_mode_type powerMode,
  output logic wakeCtlActive,
  output logic lowSpeedRun,
  output crpc_pkg::crpc_scope_type rstScope_n,
  output logic [`CRPC_NUM_MODULES-1:0] moduleRst_n,
  output logic irq
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic rstMeta;
  logic rstSync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  logic [1:0] pinSync;
  logic padLevelPrev;

  // The reset pin is inverted inside the synchroniser so that idle reads as zero.
  crpc_sync #(.WIDTH(2)) u_pin_sync (
    .clk(sys_clk),
    .rstN(rstSync_n),
    .clkEn(clkEn),
    .resetValue(2'h2),
    .d({resetPin_n, padWake}),
    .q(pinSync)
  );

  logic pinResetReq;
  logic padWakeRise;
  logic softClear;
  assign pinResetReq = pinSync[1];
  assign padWakeRise = pinSync[0] & ~padLevelPrev;
  assign softClear = pinResetReq | watchdogReset;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [`CRPC_ADDR_W-1:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;
  logic [31:0] sysCtrl;
  logic [`CRPC_EV_W-1:0] status;
  logic [`CRPC_EV_W-1:0] mask;
  logic [`CRPC_NUM_MODULES-1:0] modRstPulse;
  logic [`CRPC_EV_W-1:0] eventSet;

  logic [`CRPC_ADDR_W-1:0] next_awAddr;
  logic next_awHeld;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_wHeld;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] next_sysCtrl;
  logic [`CRPC_EV_W-1:0] next_status;
  logic [`CRPC_EV_W-1:0] next_mask;
  logic [`CRPC_NUM_MODULES-1:0] next_modRstPulse;
  logic next_irq;

  always_comb begin
    logic [31:0] byteMask;
    logic [31:0] written;
    logic [`CRPC_EV_W-1:0] readClear;
    logic doWrite;
    byteMask = '0;
    written = '0;
    readClear = '0;
    doWrite = 1'b0;
    next_awAddr = awAddr;
    next_awHeld = awHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_wHeld = wHeld;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_sysCtrl = sysCtrl;
    next_mask = mask;
    next_modRstPulse = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awAddr = s_axi_awaddr;
      next_awHeld = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
      next_wHeld = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      doWrite = 1'b1;
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `CRPC_RESP_OKAY;
    end
    for (int b = 0; b < 4; b++) begin
      byteMask[b*8 +: 8] = {8{wStrb[b]}};
    end
    written = (sysCtrl & ~byteMask) | (wData & byteMask);
    if (doWrite) begin
      unique case (awAddr)
        `CRPC_OFS_SYSCTRL: begin
          next_sysCtrl = written & `CRPC_SYSCTRL_MASK;
          if (lowSpeedRun) begin
            // Slow clock and low-power regulator stay locked until a reset.
            next_sysCtrl[`CRPC_BIT_CLK_TOP] = 1'b1;
            next_sysCtrl[`CRPC_BIT_LDO_LP] = 1'b1;
          end
        end
        `CRPC_OFS_MASK: begin
          if (wStrb[0]) begin
            next_mask = wData[`CRPC_EV_W-1:0];
          end
        end
        `CRPC_OFS_MODRST: begin
          if (wStrb[0]) begin
            next_modRstPulse = wData[`CRPC_NUM_MODULES-1:0];
          end
        end
        `CRPC_OFS_STATUS, `CRPC_OFS_MODE: begin
        end
        default: begin
          next_bresp = `CRPC_RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `CRPC_RESP_OKAY;
      next_rdata = '0;
      unique case (s_axi_araddr)
        `CRPC_OFS_SYSCTRL: next_rdata = sysCtrl;
        `CRPC_OFS_STATUS: begin
          next_rdata[`CRPC_EV_W-1:0] = status;
          readClear = status;
        end
        `CRPC_OFS_MASK: next_rdata[`CRPC_EV_W-1:0] = mask;
        `CRPC_OFS_MODRST: next_rdata[`CRPC_NUM_MODULES-1:0] = ~moduleRst_n;
        `CRPC_OFS_MODE: next_rdata[4:0] = {regulatorMode, lowSpeedRun, powerMode};
        default: next_rresp = `CRPC_RESP_SLVERR;
      endcase
    end
    // Clearing by read only drops bits the read returned; a new event in that cycle survives.
    next_status = (status & ~readClear) | eventSet;
    if (softClear) begin
      next_sysCtrl = `CRPC_SYSCTRL_RST;
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      awAddr <= '0;
      awHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRPC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CRPC_RESP_OKAY;
      sysCtrl <= `CRPC_SYSCTRL_RST;
      status <= `CRPC_STATUS_RST;
      mask <= `CRPC_MASK_RST;
      modRstPulse <= '0;
      irq <= 1'b0;
    end else if (clkEn) begin
      awAddr <= next_awAddr;
      awHeld <= next_awHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      wHeld <= next_wHeld;
      s_axi_awready <= !next_awHeld;
      s_axi_wready <= !next_wHeld;
      s_axi_arready <= !next_rvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      sysCtrl <= next_sysCtrl;
      status <= next_status;
      mask <= next_mask;
      modRstPulse <= next_modRstPulse;
      irq <= next_irq;
    end
  end

  // ****************************************************************
  // Reset scopes
  // ****************************************************************
  logic [`CRPC_CNT_W-1:0] holdCnt;
  logic holdFromPin;
  logic [`CRPC_CNT_W-1:0] next_holdCnt;
  logic next_holdFromPin;
  crpc_pkg::crpc_scope_type next_rstScope_n;

  always_comb begin
    next_holdCnt = holdCnt;
    next_holdFromPin = holdFromPin;
    if (pinResetReq) begin
      next_holdCnt = `CRPC_CNT_W'(`CRPC_RST_HOLD_CYC);
      next_holdFromPin = 1'b1;
    end else if (watchdogReset) begin
      next_holdCnt = `CRPC_CNT_W'(`CRPC_RST_HOLD_CYC);
      // A pin reset already under way keeps its wider scope.
      next_holdFromPin = holdFromPin && (holdCnt != '0);
    end else if (holdCnt != '0) begin
      next_holdCnt = holdCnt - `CRPC_CNT_W'(1);
    end
    // Debug logic falls only under the power-on reset of this block.
    next_rstScope_n.debugN = 1'b1;
    next_rstScope_n.chipN = (next_holdCnt == '0);
    next_rstScope_n.flashN = (next_holdCnt == '0) || !next_holdFromPin;
    next_rstScope_n.padN = (next_holdCnt == '0) || !next_holdFromPin;
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      holdCnt <= '0;
      holdFromPin <= 1'b0;
      rstScope_n <= '0;
    end else if (clkEn) begin
      holdCnt <= next_holdCnt;
      holdFromPin <= next_holdFromPin;
      rstScope_n <= next_rstScope_n;
    end
  end

  // Each module has its own hold counter so one module's reset never touches another.
  genvar m;
  generate
    for (m = 0; m < `CRPC_NUM_MODULES; m++) begin : g_mod_rst
      logic [`CRPC_CNT_W-1:0] modCnt;
      logic [`CRPC_CNT_W-1:0] next_modCnt;
      always_comb begin
        next_modCnt = modCnt;
        if (modRstPulse[m]) begin
          next_modCnt = `CRPC_CNT_W'(`CRPC_RST_HOLD_CYC);
        end else if (modCnt != '0) begin
          next_modCnt = modCnt - `CRPC_CNT_W'(1);
        end
      end
      always_ff @(posedge sys_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
          modCnt <= '0;
          moduleRst_n[m] <= 1'b0;
        end else if (clkEn) begin
          modCnt <= next_modCnt;
          moduleRst_n[m] <= (next_modCnt == '0) && (next_holdCnt == '0);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Power mode sequencer
  // ****************************************************************
  crpc_pkg::crpc_mode_type next_powerMode;
  logic next_lowSpeedRun;
  crpc_pkg::crpc_src_type next_sysClkSource;
  crpc_pkg::crpc_reg_type next_regulatorMode;
  crpc_pkg::crpc_clk_ctl_type next_clkCtl;
  logic next_wakeCtlActive;

  always_comb begin
    logic slowTop;
    logic wantFastInt;
    logic wantFastExt;
    slowTop = sysCtrl[`CRPC_BIT_CLK_TOP];
    next_powerMode = powerMode;
    eventSet = '0;
    unique case (powerMode)
      crpc_pkg::MODE_RUN: begin
        // The core sets its deep bit before the wait request arrives.
        if (coreSleepReq) begin
          eventSet[`CRPC_EV_LP_ENTRY] = 1'b1;
          if (!coreDeepSleep) begin
            next_powerMode = crpc_pkg::MODE_SLEEP;
          end else if (sysCtrl[`CRPC_BIT_STOP_SEL]) begin
            next_powerMode = crpc_pkg::MODE_STOP;
          end else begin
            next_powerMode = crpc_pkg::MODE_DEEP;
          end
        end
      end
      crpc_pkg::MODE_SLEEP, crpc_pkg::MODE_DEEP: begin
        if (coreWakeEvent || padWakeRise) begin
          next_powerMode = crpc_pkg::MODE_RUN;
          eventSet[`CRPC_EV_WAKE] = 1'b1;
        end
      end
      crpc_pkg::MODE_STOP: begin
        // Core events are ignored here; only the pad edge or a pin or watchdog reset restarts the clocks.
        if (padWakeRise) begin
          next_powerMode = crpc_pkg::MODE_RUN;
          eventSet[`CRPC_EV_WAKE] = 1'b1;
          eventSet[`CRPC_EV_PAD_WAKE] = 1'b1;
        end
      end
    endcase
    eventSet[`CRPC_EV_PIN_RST] = pinResetReq;
    eventSet[`CRPC_EV_WATCHDOG_RST] = watchdogReset;
    // Entry needs both the slow-source top bit and the regulator bit set, in any order.
    next_lowSpeedRun = lowSpeedRun || (slowTop && sysCtrl[`CRPC_BIT_LDO_LP]);
    if (softClear) begin
      next_powerMode = crpc_pkg::MODE_RUN;
      next_lowSpeedRun = 1'b0;
    end
    // Top bit picks the pair, the pair's own sub-select picks the member.
    if (!slowTop) begin
      next_sysClkSource = sysCtrl[`CRPC_BIT_FAST_SUB] ?
        crpc_pkg::SRC_EXT_FAST : crpc_pkg::SRC_INT_FAST;
    end else begin
      next_sysClkSource = sysCtrl[`CRPC_BIT_SLOW_SUB] ?
        crpc_pkg::SRC_EXT_SLOW : crpc_pkg::SRC_INT_SLOW;
    end
    wantFastInt = (next_sysClkSource == crpc_pkg::SRC_INT_FAST);
    wantFastExt = (next_sysClkSource == crpc_pkg::SRC_EXT_FAST);
    next_clkCtl = '0;
    next_wakeCtlActive = 1'b0;
    next_regulatorMode = next_lowSpeedRun ? crpc_pkg::REG_LOW_POWER : crpc_pkg::REG_ACTIVE;
    unique case (next_powerMode)
      crpc_pkg::MODE_RUN: begin
        next_clkCtl.fastIntEn = wantFastInt;
        next_clkCtl.fastExtEn = wantFastExt;
        next_clkCtl.slowIntEn = 1'b1;
        next_clkCtl.slowExtEn = (next_sysClkSource == crpc_pkg::SRC_EXT_SLOW);
        next_clkCtl.sysClkEn = 1'b1;
        next_clkCtl.cpuClkEn = 1'b1;
      end
      crpc_pkg::MODE_SLEEP: begin
        // Core clock off, wake controller alive, system clock keeps running.
        next_clkCtl.fastIntEn = wantFastInt;
        next_clkCtl.fastExtEn = wantFastExt;
        next_clkCtl.slowIntEn = 1'b1;
        next_clkCtl.slowExtEn = (next_sysClkSource == crpc_pkg::SRC_EXT_SLOW);
        next_clkCtl.sysClkEn = 1'b1;
        next_wakeCtlActive = 1'b1;
      end
      crpc_pkg::MODE_DEEP: begin
        // Fast sources stop; the system clock runs on only from a slow source.
        next_clkCtl.slowIntEn = 1'b1;
        next_clkCtl.slowExtEn = (next_sysClkSource == crpc_pkg::SRC_EXT_SLOW);
        next_clkCtl.sysClkEn = slowTop;
        next_wakeCtlActive = 1'b1;
        next_regulatorMode = crpc_pkg::REG_STANDBY;
      end
      crpc_pkg::MODE_STOP: begin
        next_wakeCtlActive = 1'b1;
        next_regulatorMode = crpc_pkg::REG_STANDBY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      powerMode <= crpc_pkg::MODE_RUN;
      lowSpeedRun <= 1'b0;
      sysClkSource <= crpc_pkg::SRC_INT_FAST;
      regulatorMode <= crpc_pkg::REG_ACTIVE;
      clkCtl <= '0;
      wakeCtlActive <= 1'b0;
      padLevelPrev <= 1'b0;
    end else if (clkEn) begin
      powerMode <= next_powerMode;
      lowSpeedRun <= next_lowSpeedRun;
      sysClkSource <= next_sysClkSource;
      regulatorMode <= next_regulatorMode;
      clkCtl <= next_clkCtl;
      wakeCtlActive <= next_wakeCtlActive;
      padLevelPrev <= pinSync[0];
    end
  end

endmodule : crpc_top

// ===== tb/crpc_top_sva.sv
// Port checker for the clock, reset and power block.
`timescale 1ns/100ps
module crpc_top_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic coreSleepReq,
  input wire logic coreDeepSleep,
  input wire logic padWake,
  input wire crpc_pkg::crpc_clk_ctl_type clkCtl,
  input wire crpc_pkg::crpc_src_type sysClkSource,
  input wire crpc_pkg::crpc_reg_type regulatorMode,
  input wire crpc_pkg::crpc_mode_type powerMode,
  input wire logic wakeCtlActive,
  input wire logic lowSpeedRun,
  input wire crpc_pkg::crpc_scope_type rstScope_n,
  input wire logic [7:0] moduleRst_n
);
  // ****************************************
  // Properties
  // ****************************************
  // The chip scope is low through the internal reset release, which masks those edges.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_fast;
    powerMode == crpc_pkg::MODE_RUN && rstScope_n.chipN && !sysClkSource[1]
      && $stable(sysClkSource) |-> clkCtl.fastExtEn == sysClkSource[0] && clkCtl.cpuClkEn;
  endproperty
  a_fast: assert property (p_fast) else $error("fast enable wrong");
  property p_sleep;
    powerMode == crpc_pkg::MODE_SLEEP |-> wakeCtlActive && !clkCtl.cpuClkEn
      && regulatorMode != crpc_pkg::REG_STANDBY;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_deep;
    powerMode == crpc_pkg::MODE_DEEP |-> !clkCtl.fastIntEn && !clkCtl.fastExtEn
      && clkCtl.slowIntEn && regulatorMode == crpc_pkg::REG_STANDBY;
  endproperty
  a_deep: assert property (p_deep) else $error("deep outputs wrong");
  property p_stop;
    powerMode == crpc_pkg::MODE_STOP |-> clkCtl == 6'h00
      && regulatorMode == crpc_pkg::REG_STANDBY;
  endproperty
  a_stop: assert property (p_stop) else $error("stop outputs wrong");
  property p_stop_exit;
    $past(powerMode) == crpc_pkg::MODE_STOP && powerMode != crpc_pkg::MODE_STOP
      |-> !rstScope_n.chipN || ($past(padWake, 2) || $past(padWake, 3));
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop left early");
  property p_lsr;
    $fell(lowSpeedRun) |-> !rstScope_n.chipN;
  endproperty
  a_lsr: assert property (p_lsr) else $error("low speed run lost");
  property p_entry;
    powerMode == crpc_pkg::MODE_RUN && coreSleepReq && !coreDeepSleep && rstScope_n.chipN
      |=> powerMode == crpc_pkg::MODE_SLEEP;
  endproperty
  a_entry: assert property (p_entry) else $error("sleep not entered");
  property p_mod;
    $fell(moduleRst_n[3]) && rstScope_n.chipN |-> (!moduleRst_n[3] && rstScope_n == 4'hf) [*8];
  endproperty
  a_mod: assert property (p_mod) else $error("module reset wrong");
endmodule : crpc_top_sva
bind crpc_top crpc_top_sva chk_u (.*);

// ===== tb/crpc_core_model.sv
// Core partner model: deep-sleep bit, wait request and wake events.
`timescale 1ns/100ps
module crpc_core_model (
  input wire logic sys_clk,
  input wire logic goSleep,
  input wire logic goDeep,
  input wire logic goWake,
  output logic coreSleepReq = 1'b0,
  output logic coreDeepSleep = 1'b0,
  output logic coreWakeEvent = 1'b0
);
  logic pend = 1'b0;
  // The deep bit settles a cycle before the wait request, as the core orders them.
  always @(posedge sys_clk) begin
    if (goSleep) coreDeepSleep <= goDeep;
    pend <= goSleep;
    coreSleepReq <= pend;
    coreWakeEvent <= goWake;
  end
endmodule : crpc_core_model

// ===== tb/crpc_top_test.sv
// Self-checking bench for the clock, reset and power block.
`timescale 1ns/100ps
`include "crpc_params.svh"
module crpc_top_test;
  logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, resetPin_n = 1'b1, goDeep = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, moduleRst_n;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, kick = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wakeCtlActive, lowSpeedRun, irq, coreSleepReq, coreDeepSleep, coreWakeEvent;
  logic goSleep, goWake, watchdogReset, padWake;
  crpc_pkg::crpc_clk_ctl_type clkCtl;
  crpc_pkg::crpc_src_type sysClkSource;
  crpc_pkg::crpc_reg_type regulatorMode;
  crpc_pkg::crpc_mode_type powerMode;
  crpc_pkg::crpc_scope_type rstScope_n;
  int nFail = 0, nChecks = 0;
  assign {padWake, watchdogReset, goWake, goSleep} = kick;
  crpc_top dut_u (.*);
  crpc_core_model core_u (.*);
  always #5 sys_clk = ~sys_clk;
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    nChecks++;
    if (s !== e) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic st(input logic [1:0] m, input logic [1:0] r, input logic [5:0] c);
    chk("mode", 32'(m), 32'(powerMode));
    chk("regulator", 32'(r), 32'(regulatorMode));
    chk("clocks", 32'(c), 32'(clkCtl));
  endtask : st
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic pulse(input logic [3:0] k);
    kick <= k;
    @(posedge sys_clk);
    kick <= 4'h0;
    cyc(5);
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    if (er === 2'h0) chk("rdata", e, s_axi_rdata);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rdc
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : endOfTest
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
    chk("scope", 32'h0f, 32'(rstScope_n));
    st(crpc_pkg::MODE_RUN, crpc_pkg::REG_ACTIVE, 6'b101011);
    rdc(`CRPC_OFS_SYSCTRL, 32'h0, `CRPC_RESP_OKAY);
    rdc(8'h40, 32'h0, `CRPC_RESP_SLVERR);
    wr(8'h44, 32'h1);
    chk("bresp", 32'(`CRPC_RESP_SLVERR), 32'(bresp));
    $display("test reset finished");
    for (int i = 0; i < 8; i++) begin
      wr(`CRPC_OFS_SYSCTRL, 32'(i) << 12);
      cyc(2);
      chk("source", 32'(i[2] ? 2 + i[0] : i[1]), 32'(sysClkSource));
    end
    wr(`CRPC_OFS_SYSCTRL, 32'h0);
    $display("test clock select finished");
    pulse(4'b0001);
    st(crpc_pkg::MODE_SLEEP, crpc_pkg::REG_ACTIVE, 6'b101010);
    chk("wake ctl", 32'h1, 32'(wakeCtlActive));
    pulse(4'b0010);
    st(crpc_pkg::MODE_RUN, crpc_pkg::REG_ACTIVE, 6'b101011);
    goDeep <= 1'b1;
    pulse(4'b0001);
    st(crpc_pkg::MODE_DEEP, crpc_pkg::REG_STANDBY, 6'b001000);
    pulse(4'b0010);
    chk("irq", 32'h0, 32'(irq));
    $display("test sleep finished");
    wr(`CRPC_OFS_MASK, 32'h1);
    chk("bresp", 32'(`CRPC_RESP_OKAY), 32'(bresp));
    wr(`CRPC_OFS_SYSCTRL, 32'h1);
    pulse(4'b0001);
    st(crpc_pkg::MODE_STOP, crpc_pkg::REG_STANDBY, 6'h00);
    pulse(4'b0010);
    st(crpc_pkg::MODE_STOP, crpc_pkg::REG_STANDBY, 6'h00);
    chk("irq", 32'h0, 32'(irq));
    pulse(4'b1000);
    st(crpc_pkg::MODE_RUN, crpc_pkg::REG_ACTIVE, 6'b101011);
    chk("irq", 32'h1, 32'(irq));
    rdc(`CRPC_OFS_STATUS, 32'h07, `CRPC_RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    wr(`CRPC_OFS_SYSCTRL, 32'h0);
    $display("test stop finished");
    wr(`CRPC_OFS_SYSCTRL, 32'h4002);
    cyc(2);
    chk("lsr", 32'h1, 32'(lowSpeedRun));
    chk("source", 32'h2, 32'(sysClkSource));
    chk("regulator", 32'h2, 32'(regulatorMode));
    wr(`CRPC_OFS_SYSCTRL, 32'h0);
    rdc(`CRPC_OFS_SYSCTRL, 32'h4002, `CRPC_RESP_OKAY);
    rdc(`CRPC_OFS_MODE, 32'h14, `CRPC_RESP_OKAY);
    chk("lsr", 32'h1, 32'(lowSpeedRun));
    $display("test low speed run finished");
    pulse(4'b0100);
    chk("scope", 32'h0b, 32'(rstScope_n));
    chk("modrst", 32'h00, 32'(moduleRst_n));
    chk("lsr", 32'h0, 32'(lowSpeedRun));
    cyc(20);
    chk("scope", 32'h0f, 32'(rstScope_n));
    rdc(`CRPC_OFS_MASK, 32'h1, `CRPC_RESP_OKAY);
    resetPin_n <= 1'b0;
    cyc(6);
    chk("scope", 32'h08, 32'(rstScope_n));
    resetPin_n <= 1'b1;
    cyc(22);
    chk("scope", 32'h0f, 32'(rstScope_n));
    $display("test system resets finished");
    wr(`CRPC_OFS_MODRST, 32'h08);
    chk("modrst", 32'hf7, 32'(moduleRst_n));
    chk("scope", 32'h0f, 32'(rstScope_n));
    rdc(`CRPC_OFS_MODRST, 32'h08, `CRPC_RESP_OKAY);
    // A low enable freezes the hold count, so the module stays in reset past its 16 cycles.
    clkEn <= 1'b0;
    cyc(20);
    chk("modrst", 32'hf7, 32'(moduleRst_n));
    clkEn <= 1'b1;
    cyc(20);
    chk("modrst", 32'hff, 32'(moduleRst_n));
    $display("test module reset finished");
    endOfTest();
  end
  // The whole sequence needs well under ten microseconds; a hang is cut off here.
  initial begin
    #50us;
    nFail++;
    endOfTest();
  end
endmodule : crpc_top_test
